// ---- design/sdd_defs.svh ----
// Constants for the sigma-delta decimation chain
`ifndef SDD_DEFS_SVH
`define SDD_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SDD_CLK_PERIOD_NS 20
`define SDD_MOD_PERIOD_NS 1000
`define SDD_TICK_CYC (`SDD_MOD_PERIOD_NS / `SDD_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Decimation and normalisation
// ----------------------------------------------------------------------
`define SDD_DEC1 24
`define SDD_DEC2 4
// Round(2^32 / 24^3): turns the stage-one sum into a Q1.16 fraction
`define SDD_NORM1_MUL 19'h4_BDA1
`define SDD_NORM1_SHIFT 16
// 4^3 = 2^6, so stage two normalises with an exact shift
`define SDD_NORM2_SHIFT 6
`define SDD_FILL_WORDS 4

// ----------------------------------------------------------------------
// Trim arithmetic and buffering
// ----------------------------------------------------------------------
`define SDD_TRIM_T_SHIFT 4
`define SDD_TRIM_X_FRAC 16
`define SDD_FIFO_DEPTH 16

`endif

// ---- design/sdd_pkg.sv ----
// Types shared by the sigma-delta decimation chain
`default_nettype none

package sdd_pkg;

  typedef logic signed [15:0] sdd_coef_t;
  typedef logic signed [11:0] sdd_temp_t;
  typedef logic signed [23:0] sdd_sample_t;
  typedef logic [16:0] sdd_word_t;

  // Each trim term is base + slope * temperature / 16
  typedef struct packed {
    sdd_coef_t off_base;
    sdd_coef_t off_slope;
    sdd_coef_t sens_base;
    sdd_coef_t sens_slope;
    sdd_coef_t lin_base;
    sdd_coef_t lin_slope;
  } sdd_trim_s;

endpackage : sdd_pkg

`default_nettype wire

// ---- design/sdd_fifo.sv ----
// Sample FIFO with registered read data
`default_nettype none

module sdd_fifo #(
  parameter int W = 24,
  parameter int DEPTH = 16
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Read data valid
  input wire logic out_ready, // Consumer takes word
  output logic [W-1:0] out_data // Read data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] cnt_r;
  logic out_valid_r;
  logic [W-1:0] out_data_r;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : next_ptr

  assign in_ready = (cnt_r != (AW + 1)'(DEPTH));
  assign push = in_valid && in_ready;
  // Refill the output register whenever it is empty or being taken
  assign pop = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign out_valid = out_valid_r;
  assign out_data = out_data_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      case ({push, pop})
        2'b10: cnt_r <= cnt_r + (AW + 1)'(1);
        2'b01: cnt_r <= cnt_r - (AW + 1)'(1);
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r <= mem_r[rd_ptr_r];
    end else if (out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

endmodule : sdd_fifo

`default_nettype wire

// ---- design/sdd_chain.sv ----
// Sigma-delta modulator, two sinc3 decimators, trim and output buffer
//
// Function
// - Second-order modulator yields single-bit stream
// - Modulator and first stage run 1 MHz
// - Signal path is pure two-sample delay
// - Two cascaded sinc3 decimators make words
// - First stage decimates 24, divides 24 cubed
// - Second stage decimates 4, divides 4 cubed
// - Trim offset, sensitivity, nonlinearity over temperature
// - Trimmed samples go to following low-pass
`default_nettype none
`include "sdd_defs.svh"

module sdd_chain #(
  parameter int IN_W = 16, // Front-end sample width
  parameter int FIFO_DEPTH = `SDD_FIFO_DEPTH // Output buffer depth
) (
  input wire logic clk, // 50 MHz clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic signed [IN_W-1:0] afe_sample, // Front-end voltage
  input wire sdd_pkg::sdd_temp_t temp_word, // Die temperature
  input wire sdd_pkg::sdd_trim_s trim_coef, // Trim coefficients
  output logic m_valid, // Sample available to low-pass
  input wire logic m_ready, // Low-pass takes sample
  output sdd_pkg::sdd_sample_t m_data, // Trimmed sample
  output logic mod_bit, // Modulator bitstream
  output logic overrun // Sticky, a sample was lost
);

  localparam int TICK_N = `SDD_TICK_CYC;
  localparam int TCW = $clog2(TICK_N);
  localparam int IW = IN_W + 4;
  localparam logic signed [IW-1:0] FS = IW'(1) <<< (IN_W - 1);

  // ----------------------------------------------------------------------
  // Modulator clock and second-order loop
  // ----------------------------------------------------------------------
  logic [TCW-1:0] tick_cnt_r;
  logic tick_r;
  logic signed [IW-1:0] i1_r;
  logic signed [IW-1:0] i2_r;
  logic signed [IW-1:0] fb;
  logic signed [IW-1:0] ax;
  logic q_bit;
  logic mod_bit_r;
  logic s0_stb_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TCW'(TICK_N - 1));
      if (tick_cnt_r == TCW'(TICK_N - 1)) begin
        tick_cnt_r <= '0;
      end else begin
        tick_cnt_r <= tick_cnt_r + TCW'(1);
      end
    end
  end

  assign q_bit = ~i2_r[IW-1];
  assign fb = q_bit ? FS : -FS;
  assign ax = IW'(afe_sample);

  // Delaying integrators with feedback gains 1 and 2 give z^-2 signal
  // transfer and second-order noise shaping
  always_ff @(posedge clk) begin
    if (reset) begin
      i1_r <= '0;
      i2_r <= '0;
      mod_bit_r <= 1'b0;
      s0_stb_r <= 1'b0;
    end else begin
      s0_stb_r <= tick_r;
      if (tick_r) begin
        i1_r <= i1_r + ax - fb;
        i2_r <= i2_r + i1_r - (fb <<< 1);
        mod_bit_r <= q_bit;
      end
    end
  end

  // ----------------------------------------------------------------------
  // First sinc3 stage, decimate by 24
  // ----------------------------------------------------------------------
  logic [14:0] a1_r, a2_r, a3_r, z1_r, z2_r, z3_r, sum1_r;
  logic [14:0] c1a, c2a, c3a;
  logic [4:0] ph1_r;
  logic dec1_hit;
  logic s1_stb_r;
  logic n1_stb_r;
  logic [33:0] prod1;
  sdd_pkg::sdd_word_t out1_r;

  assign dec1_hit = s0_stb_r && (ph1_r == 5'(`SDD_DEC1 - 1));

  // Modular integrator arithmetic: wrap-around cancels in the combs
  always_ff @(posedge clk) begin
    if (reset) begin
      a1_r <= '0;
      a2_r <= '0;
      a3_r <= '0;
      ph1_r <= '0;
    end else if (s0_stb_r) begin
      a1_r <= a1_r + {14'h0, mod_bit_r};
      a2_r <= a2_r + a1_r;
      a3_r <= a3_r + a2_r;
      ph1_r <= dec1_hit ? '0 : ph1_r + 5'h1;
    end
  end

  assign c1a = a3_r - z1_r;
  assign c2a = c1a - z2_r;
  assign c3a = c2a - z3_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      z1_r <= '0;
      z2_r <= '0;
      z3_r <= '0;
      sum1_r <= '0;
      s1_stb_r <= 1'b0;
    end else begin
      s1_stb_r <= dec1_hit;
      if (dec1_hit) begin
        z1_r <= a3_r;
        z2_r <= c1a;
        z3_r <= c2a;
        sum1_r <= c3a;
      end
    end
  end

  // Divide by 24^3 with a rounded reciprocal; full scale gives 1.0
  assign prod1 = 34'(sum1_r) * 34'(`SDD_NORM1_MUL)
               + (34'(1) << (`SDD_NORM1_SHIFT - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      out1_r <= '0;
      n1_stb_r <= 1'b0;
    end else begin
      n1_stb_r <= s1_stb_r;
      if (s1_stb_r) begin
        out1_r <= prod1[32:16];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Second sinc3 stage, decimate by 4, and fill gate
  // ----------------------------------------------------------------------
  logic [22:0] b1_r, b2_r, b3_r, y1_r, y2_r, y3_r, sum2_r;
  logic [22:0] c1b, c2b, c3b;
  logic [1:0] ph2_r;
  logic dec2_hit;
  logic s2_stb_r;
  logic [2:0] fill_r;
  logic word_stb_r;
  sdd_pkg::sdd_word_t x_r;

  assign dec2_hit = n1_stb_r && (ph2_r == 2'(`SDD_DEC2 - 1));

  always_ff @(posedge clk) begin
    if (reset) begin
      b1_r <= '0;
      b2_r <= '0;
      b3_r <= '0;
      ph2_r <= '0;
    end else if (n1_stb_r) begin
      b1_r <= b1_r + 23'(out1_r);
      b2_r <= b2_r + b1_r;
      b3_r <= b3_r + b2_r;
      ph2_r <= dec2_hit ? '0 : ph2_r + 2'h1;
    end
  end

  assign c1b = b3_r - y1_r;
  assign c2b = c1b - y2_r;
  assign c3b = c2b - y3_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      y1_r <= '0;
      y2_r <= '0;
      y3_r <= '0;
      sum2_r <= '0;
      s2_stb_r <= 1'b0;
    end else begin
      s2_stb_r <= dec2_hit;
      if (dec2_hit) begin
        y1_r <= b3_r;
        y2_r <= c1b;
        y3_r <= c2b;
        sum2_r <= c3b;
      end
    end
  end

  // The first words carry the start-up transient of both stages
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_r <= '0;
      word_stb_r <= 1'b0;
      x_r <= '0;
    end else begin
      word_stb_r <= s2_stb_r && (fill_r == 3'(`SDD_FILL_WORDS));
      if (s2_stb_r && fill_r != 3'(`SDD_FILL_WORDS)) begin
        fill_r <= fill_r + 3'h1;
      end
      if (s2_stb_r) begin
        x_r <= 17'(sum2_r >> `SDD_NORM2_SHIFT);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Temperature trim
  // ----------------------------------------------------------------------
  function automatic sdd_pkg::sdd_sample_t coef_at(
    input sdd_pkg::sdd_coef_t base,
    input sdd_pkg::sdd_coef_t slope,
    input sdd_pkg::sdd_temp_t t
  );
    logic signed [27:0] p;
    p = slope * t;
    return 24'(base) + 24'(p >>> `SDD_TRIM_T_SHIFT);
  endfunction : coef_at

  sdd_pkg::sdd_sample_t tc0_r, tc1_r, tc2_r, y;
  sdd_pkg::sdd_word_t xa_r;
  logic trim_stb_r;
  logic signed [17:0] xs;
  logic signed [35:0] xsq;
  logic signed [41:0] p1, p2;

  always_ff @(posedge clk) begin
    if (reset) begin
      tc0_r <= '0;
      tc1_r <= '0;
      tc2_r <= '0;
      xa_r <= '0;
      trim_stb_r <= 1'b0;
    end else begin
      trim_stb_r <= word_stb_r;
      if (word_stb_r) begin
        tc0_r <= coef_at(trim_coef.off_base, trim_coef.off_slope,
                         temp_word);
        tc1_r <= coef_at(trim_coef.sens_base, trim_coef.sens_slope,
                         temp_word);
        tc2_r <= coef_at(trim_coef.lin_base, trim_coef.lin_slope,
                         temp_word);
        xa_r <= x_r;
      end
    end
  end

  // Offset plus gain times x plus curvature times x squared, Q1.16 x
  assign xs = signed'({1'b0, xa_r});
  assign xsq = xs * xs;
  assign p1 = tc1_r * xs;
  assign p2 = tc2_r * signed'(xsq[33:16]);
  assign y = tc0_r + 24'(p1 >>> `SDD_TRIM_X_FRAC)
           + 24'(p2 >>> `SDD_TRIM_X_FRAC);

  // ----------------------------------------------------------------------
  // Hand-off to the low-pass stage
  // ----------------------------------------------------------------------
  // The modulator cannot pause, so a full buffer costs a sample and
  // raises the sticky flag rather than stalling the filters
  logic hold_v_r;
  sdd_pkg::sdd_sample_t hold_d_r;
  logic f_in_ready;
  logic overrun_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      hold_v_r <= 1'b0;
      hold_d_r <= '0;
      overrun_r <= 1'b0;
    end else if (trim_stb_r) begin
      if (!hold_v_r || f_in_ready) begin
        hold_v_r <= 1'b1;
        hold_d_r <= y;
      end else begin
        overrun_r <= 1'b1;
      end
    end else if (f_in_ready) begin
      hold_v_r <= 1'b0;
    end
  end

  sdd_fifo #(
    .W($bits(sdd_pkg::sdd_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(hold_v_r),
    .in_ready(f_in_ready),
    .in_data(hold_d_r),
    .out_valid(m_valid),
    .out_ready(m_ready),
    .out_data(m_data)
  );

  assign mod_bit = mod_bit_r;
  assign overrun = overrun_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_tick_period: assert property (@(posedge clk) disable iff (reset)
    tick_r |=> !tick_r ##(TICK_N - 1) tick_r)
    else $error("modulator tick period wrong");

  chk_bit_hold: assert property (@(posedge clk) disable iff (reset)
    !tick_r |=> $stable(mod_bit_r))
    else $error("bitstream changed between ticks");

  chk_mod_sign: assert property (@(posedge clk) disable iff (reset)
    tick_r |=> mod_bit_r == ($past(i2_r) >= 0))
    else $error("quantiser does not follow second integrator");

  chk_dec1_phase: assert property (@(posedge clk) disable iff (reset)
    s1_stb_r |-> $past(s0_stb_r) && $past(ph1_r) == 5'(`SDD_DEC1 - 1))
    else $error("stage one decimation phase wrong");

  chk_norm1_range: assert property (@(posedge clk) disable iff (reset)
    s1_stb_r |=> out1_r <= 17'h1_0000)
    else $error("stage one word exceeds unity");

  chk_dec2_phase: assert property (@(posedge clk) disable iff (reset)
    s2_stb_r |-> $past(n1_stb_r) && $past(ph2_r) == 2'(`SDD_DEC2 - 1))
    else $error("stage two decimation phase wrong");

  chk_chain_order: assert property (@(posedge clk) disable iff (reset)
    n1_stb_r |-> $past(s1_stb_r) ##0 !s2_stb_r)
    else $error("stage strobes out of order");

  chk_reset_clear: assert property (@(posedge clk)
    $past(reset) |-> a3_r == '0 && b3_r == '0 && ph1_r == '0 && fill_r == '0)
    else $error("filter state not cleared by reset");

  chk_fill_gate: assert property (@(posedge clk) disable iff (reset)
    s2_stb_r && fill_r != 3'(`SDD_FILL_WORDS) |=> !word_stb_r)
    else $error("word flagged before filters filled");

  chk_trim_flow: assert property (@(posedge clk) disable iff (reset)
    word_stb_r |=> trim_stb_r ##1 (hold_v_r || overrun_r))
    else $error("trimmed word not delivered");

  chk_hold_stable: assert property (@(posedge clk) disable iff (reset)
    hold_v_r && !f_in_ready |=> hold_v_r && $stable(hold_d_r))
    else $error("held sample lost under back-pressure");

endmodule : sdd_chain

`default_nettype wire

// ---- sim/sdd_afe_model.sv ----
// Behavioural analog front end that feeds the modulator input
`default_nettype none

module sdd_afe_model (
  input wire logic clk, // System clock
  input wire logic slow, // Slew-limit the output
  input wire logic signed [15:0] level, // Target voltage word
  output logic signed [15:0] afe_sample // Voltage to the modulator
);
  timeunit 1ns;
  timeprecision 1ns;

  logic signed [16:0] diff;

  assign diff = 17'(level) - 17'(afe_sample);

  initial afe_sample = 16'sh0000;

  // A settling front end reaches a new level in steps, not at once
  always @(posedge clk) begin
    if (!slow || (diff < 17'sh0_0040 && diff > -17'sh0_0040)) begin
      afe_sample <= level;
    end else if (diff > 0) begin
      afe_sample <= afe_sample + 16'sh0040;
    end else begin
      afe_sample <= afe_sample - 16'sh0040;
    end
  end
endmodule : sdd_afe_model

`default_nettype wire

// ---- sim/sdd_chain_tb_top.sv ----
// Self-checking bench for the sigma-delta decimation chain
`default_nettype none

module sdd_chain_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TICK = 50;
  localparam int WORD = 4800; // 96 ticks per stage-two word
  localparam int XQ = 40960; // Input 0x2000 as Q1.16 ones density
  localparam int TOL = 96; // Modulator noise left after decimation

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b1;
  logic signed [15:0] level = 16'sh2000;
  logic signed [15:0] afe_sample;
  sdd_pkg::sdd_temp_t temp_word = 12'sh010;
  sdd_pkg::sdd_trim_s trim_coef = '0;
  logic m_valid, mod_bit, overrun, armed, last_bit;
  logic m_ready = 1'b1;
  sdd_pkg::sdd_sample_t m_data, got;
  sdd_pkg::sdd_trim_s set_a, sets[3];
  int ts[3] = '{32, 64, -64};
  int miscompares = 0;
  int num_checks = 0;
  int gap;

  always #10 clk = ~clk;

  sdd_afe_model afe (.clk(clk), .slow(slow), .level(level),
    .afe_sample(afe_sample));

  // Small buffer so that it fills within a short run
  sdd_chain #(.FIFO_DEPTH(2)) dut (.clk(clk), .reset(reset),
    .afe_sample(afe_sample), .temp_word(temp_word),
    .trim_coef(trim_coef), .m_valid(m_valid), .m_ready(m_ready),
    .m_data(m_data), .mod_bit(mod_bit), .overrun(overrun));

  // ------
  // Shared tasks
  // ------
  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input sdd_pkg::sdd_sample_t seen,
      input sdd_pkg::sdd_sample_t exp, input int tol, input string what);
    int d;
    d = int'(seen) - int'(exp);
    num_checks++;
    if ($isunknown(seen) || d > tol || d < -tol) begin
      miscompares++;
      $display("[FAIL] %0t %s: saw %0d want %0d", $time, what, seen, exp);
    end
  endtask : check

  function automatic sdd_pkg::sdd_sample_t trim_y(
      input sdd_pkg::sdd_trim_s c, input int t);
    longint c0, c1, c2;
    c0 = longint'(c.off_base) + ((longint'(c.off_slope) * t) >>> 4);
    c1 = longint'(c.sens_base) + ((longint'(c.sens_slope) * t) >>> 4);
    c2 = longint'(c.lin_base) + ((longint'(c.lin_slope) * t) >>> 4);
    return 24'(c0 + ((c1 * XQ) >>> 16) + ((c2 * ((XQ * XQ) >>> 16)) >>> 16));
  endfunction : trim_y

  task automatic take_word(output sdd_pkg::sdd_sample_t d);
    int n;
    for (n = 0; n < WORD + 200; n++) begin
      @(posedge clk);
      if (m_valid === 1'b1 && m_ready === 1'b1) break;
    end
    if (n == WORD + 200) begin
      miscompares++;
      $display("[FAIL] %0t no output word", $time);
      give_verdict();
    end
    d = m_data;
  endtask : take_word

  // Bit changes must stay on the 1 MHz tick grid
  always @(posedge clk) begin
    if (reset) begin
      armed = 1'b0;
      gap = 0;
    end else begin
      gap++;
      if (mod_bit !== last_bit) begin
        if (armed) check(24'(gap % TICK), '0, 0, "bit timing");
        armed = 1'b1;
        gap = 0;
      end
    end
    last_bit = mod_bit;
  end

  // ------
  // Scenarios
  // ------
  task automatic sc_fill();
    int n, ones;
    ones = 0;
    check(24'({m_valid, mod_bit, overrun}), '0, 0, "reset flags");
    check(m_data, '0, 0, "reset data");
    trim_coef <= set_a;
    reset <= 1'b0;
    for (n = 0; n < 5 * WORD + 300; n++) begin
      @(posedge clk);
      if (n >= 200 && n < 9800) ones += mod_bit;
      if (m_valid === 1'b1) break;
    end
    check(24'(ones), 24'h00_1770, 250, "bit density");
    check(24'(n > 4 * WORD && n < 5 * WORD + 200), 24'h00_0001, 0,
      "fill time");
    // The word seen at the break is consumed at this same edge, so take it now
    got = m_data;
    check(got, trim_y(set_a, 16), TOL, "first word");
  endtask : sc_fill

  task automatic sc_trim();
    for (int i = 0; i < 3; i++) begin
      trim_coef <= sets[i];
      temp_word <= 12'(ts[i]);
      take_word(got);
      check(got, trim_y(sets[i], ts[i]), TOL, "trim");
    end
  endtask : sc_trim

  task automatic sc_overrun();
    // Temperature steps mid-word so each stored word carries its own
    m_ready <= 1'b0;
    trim_coef <= set_a;
    temp_word <= 12'sh000;
    repeat (WORD / 2) @(posedge clk);
    for (int i = 1; i <= 4; i++) begin
      repeat (WORD) @(posedge clk);
      temp_word <= 12'(16 * i);
    end
    check(24'(overrun), '0, 0, "early overrun");
    repeat (2500) @(posedge clk);
    check(24'(overrun), 24'h00_0001, 0, "overrun");
    m_ready <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      take_word(got);
      check(got, trim_y(set_a, 16 * i), TOL, "drain order");
    end
    repeat (3) @(posedge clk);
    check(24'(m_valid), '0, 0, "empty");
  endtask : sc_overrun

  task automatic sc_rereset();
    logic any;
    any = 1'b0;
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    check(24'({m_valid, mod_bit, overrun}), '0, 0, "second reset");
    reset <= 1'b0;
    repeat (40) begin
      @(posedge clk);
      any = any | mod_bit | m_valid;
    end
    check(24'(any), '0, 0, "restart idle");
  endtask : sc_rereset

  initial begin
    set_a = '{16'sh03E8, 16'sh0400, 16'sh4000, 16'sh0000, 16'sh0000,
      16'sh0000};
    sets[0] = set_a;
    sets[1] = '{16'shF830, 16'sh0000, 16'sh2000, 16'sh0100, 16'sh0000,
      16'sh0000};
    sets[2] = '{16'sh0000, 16'sh0000, 16'sh4000, 16'sh0000, 16'sh2000,
      16'sh0080};
    repeat (20) @(posedge clk);
    sc_fill();
    sc_trim();
    sc_overrun();
    sc_rereset();
    give_verdict();
  end
endmodule : sdd_chain_tb_top

`default_nettype wire
